//--- core/nested_irq_regs.svh
// constants of the interrupt acknowledge and nesting block
// assumes a byte-wide status word owned jointly with the cpu core
`ifndef NESTED_IRQ_REGS_SVH
`define NESTED_IRQ_REGS_SVH

// status word field positions
`define PSW_IE_BIT 7
`define PSW_IN_SERVICE_LEVEL_BIT1_BIT 2
`define PSW_IN_SERVICE_LEVEL_BIT0_BIT 1
// status word after reset: enable clear, in-service level bits 11
`define PSW_RESET_VALUE 8'h06
`define ISP_NONE_IN_SERVICE 2'h3
`define ISP_LEVEL_0_OR_1 2'h0

// vector addresses
`define BREAK_VECTOR_ADDR 20'h0007e
`define IRQ_VECTOR_STEP 20'h00002

// servicing time, in cpu clocks, from request to vectored servicing
`define ACK_MIN_CLOCKS 9
`define ACK_MAX_CLOCKS 16
// clocks from the acknowledge decision to the branch pulse
`define ACK_SEQ_CLOCKS 3

`endif

//--- core/nested_irq_pkg.sv
// types shared by the acknowledge controller, its checker and the bench
// assumes the sequencer classifies each finished instruction itself
package nested_irq_pkg;

	// class of the instruction that finishes on instr_done
	typedef enum logic [3:0] {
		CLASS_NORMAL = 4'h0,
		CLASS_BREAK = 4'h1,
		CLASS_RET_BREAK = 4'h2,
		CLASS_RET_IRQ = 4'h3,
		CLASS_ENABLE = 4'h4,
		CLASS_DISABLE = 4'h5,
		CLASS_PSW_WRITE = 4'h6,
		CLASS_SKIP = 4'h7,
		CLASS_IRQ_REG_WRITE = 4'h8
	} instr_class_type;

	typedef enum logic [3:0] {
		SEQ_IDLE = 4'b0001,
		SEQ_SAVE_PSW = 4'b0010,
		SEQ_SAVE_PC = 4'b0100,
		SEQ_BRANCH = 4'b1000
	} seq_state_type;

	typedef struct packed {
		seq_state_type state;
		logic ie;
		logic [1:0] isp;
		logic in_break;
		logic [3:0] age;
		logic [7:0] saved_psw;
		logic [19:0] vector;
		logic is_break;
		logic [5:0] source;
	} ctrl_state_type;

endpackage

//--- core/irq_arbiter.sv
// picks one acknowledgeable maskable request out of all sources
// assumes source 0 has the highest fixed default priority
`timescale 1ns/100ps

module irq_arbiter #(
	parameter int SOURCES = 32,
	parameter int IDX_W = 6
) (
	input wire logic [SOURCES-1:0] request_flag,
	input wire logic [SOURCES-1:0] request_mask_flag,
	input wire logic [SOURCES-1:0] priority_high_bit,
	input wire logic [SOURCES-1:0] priority_low_bit,
	output logic found,
	output logic [IDX_W-1:0] pick_index,
	output logic [1:0] pick_code
);

	logic [SOURCES:0] hit;
	logic [1:0] best_code [SOURCES:0];
	logic [IDX_W-1:0] best_index [SOURCES:0];

	assign hit[SOURCES] = 1'b0;
	assign best_code[SOURCES] = 2'h3;
	assign best_index[SOURCES] = '0;

	// chain runs from the lowest default priority upward, so on equal
	// codes the lower index overrides
	for (genvar i = 0; i < SOURCES; i++) begin : g_src
		logic live;
		logic [1:0] code;
		logic take;
		assign live = request_flag[i] & ~request_mask_flag[i];
		assign code = {priority_high_bit[i], priority_low_bit[i]};
		assign take = live & (~hit[i+1] | (code <= best_code[i+1]));
		assign hit[i] = hit[i+1] | live;
		assign best_code[i] = take ? code : best_code[i+1];
		assign best_index[i] = take ? IDX_W'(i) : best_index[i+1];
	end

	assign found = hit[0];
	assign pick_index = best_index[0];
	assign pick_code = best_code[0];

endmodule

//--- core/nested_irq_ack.sv
// interrupt acknowledge, nesting and in-service level control
// assumes the sequencer pulses instr_done once per finished instruction,
// stalls while service_busy is high and performs the pushes it is told
`timescale 1ns/100ps
`include "nested_irq_regs.svh"

// Behaviour
// - a break instruction is always acknowledged, no enable or mask blocks it
// - break pushes status word then pc, clears enable, vectors to 0007eh
// - every acknowledge clears enable; nesting needs the enable instruction or a status word write
// - with enable set, nest only requests of strictly higher level
// - level-0 service with enable set also accepts further level-0 requests
// - refused requests stay pending; one main instruction runs after return
// - in-service bits 00 level 0/1, 01 level 2, 10 level 3, 11 none
// - priority code 00 level 0 highest up to 11 level 3 lowest
// - maskable needs enable; break always; break handler accepts all levels until it takes its first maskable acknowledge
// - nesting uses programmable levels, not default order
// - request during a hold instruction waits for the next one to finish
// - hold class: status writes, returns, enable, disable, skips, flag writes
// - maskable acknowledge with nonzero code loads in-service bits code-1
// - acknowledgeable when flag set and mask clear; vectored only if enabled
// - highest level first, then highest default priority
// - vectored servicing 9 to 16 clocks after the request
module nested_irq_ack #(
	parameter int SOURCES = 32,
	parameter logic [19:0] IRQ_VECTOR_BASE = 20'h00004
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [SOURCES-1:0] request_flag,
	input wire logic [SOURCES-1:0] request_mask_flag,
	input wire logic [SOURCES-1:0] priority_high_bit,
	input wire logic [SOURCES-1:0] priority_low_bit,
	input wire logic instr_done,
	input wire nested_irq_pkg::instr_class_type instr_class,
	input wire logic [7:0] psw_write_data,
	input wire logic [7:0] stack_psw_data,
	output logic global_irq_enable,
	output logic in_service_level_bit1,
	output logic in_service_level_bit0,
	output logic [7:0] program_status_word,
	output logic service_busy,
	output logic ack_pulse,
	output logic ack_is_break,
	output logic [5:0] ack_source,
	output logic push_psw_valid,
	output logic [7:0] push_psw_data,
	output logic push_pc_valid,
	output logic pc_load_valid,
	output logic [19:0] pc_load_addr
);

	localparam int IDX_W = 6;
	localparam int MIN_WAIT = `ACK_MIN_CLOCKS - `ACK_SEQ_CLOCKS;
	localparam logic [3:0] WAIT_DONE = 4'(MIN_WAIT);

	// the source index travels in six bits, so more sources cannot be served
	if (SOURCES < 1 || SOURCES > 64) begin : g_bad_sources
		$error("nested_irq_ack: SOURCES must lie in 1..64");
	end

	nested_irq_pkg::ctrl_state_type q;
	nested_irq_pkg::ctrl_state_type d;

	logic found;
	logic [IDX_W-1:0] pick_index;
	logic [1:0] pick_code;

	irq_arbiter #(
		.SOURCES(SOURCES),
		.IDX_W(IDX_W)
	) u_arbiter (
		.request_flag(request_flag),
		.request_mask_flag(request_mask_flag),
		.priority_high_bit(priority_high_bit),
		.priority_low_bit(priority_low_bit),
		.found(found),
		.pick_index(pick_index),
		.pick_code(pick_code)
	);

	logic hold_class;
	logic level_ok;
	logic take_mask;
	logic [7:0] psw_image;

	always_comb begin
		unique case (instr_class)
			nested_irq_pkg::CLASS_RET_BREAK,
			nested_irq_pkg::CLASS_RET_IRQ,
			nested_irq_pkg::CLASS_ENABLE,
			nested_irq_pkg::CLASS_DISABLE,
			nested_irq_pkg::CLASS_PSW_WRITE,
			nested_irq_pkg::CLASS_SKIP,
			nested_irq_pkg::CLASS_IRQ_REG_WRITE: hold_class = 1'b1;
			default: hold_class = 1'b0;
		endcase
	end

	// isp 00 passes level 0 only (level 0 again, level 1 never), 01 levels
	// 0..1, 10 levels 0..2, 11 everything: the code must not exceed isp
	assign level_ok = (pick_code <= q.isp) | q.in_break;
	// a refused request is simply left standing in its flag, so it is
	// retried at every later boundary; returns are hold class, which
	// forces one main instruction before it is taken
	assign take_mask = found & q.ie & level_ok & ~hold_class
		& (q.age >= WAIT_DONE);

	always_comb begin
		psw_image = 8'h00;
		psw_image[`PSW_IE_BIT] = q.ie;
		psw_image[`PSW_IN_SERVICE_LEVEL_BIT1_BIT] = q.isp[1];
		psw_image[`PSW_IN_SERVICE_LEVEL_BIT0_BIT] = q.isp[0];
	end

	always_comb begin
		d = q;
		// requests age while pending; a new one waits the least time
		if (!found) begin
			d.age = 4'h0;
		end else if (q.age < WAIT_DONE) begin
			d.age = q.age + 4'h1;
		end
		unique case (q.state)
			nested_irq_pkg::SEQ_IDLE: begin
				if (instr_done && instr_class == nested_irq_pkg::CLASS_BREAK) begin
					d.saved_psw = psw_image;
					d.ie = 1'b0;
					d.in_break = 1'b1;
					d.vector = `BREAK_VECTOR_ADDR;
					d.is_break = 1'b1;
					d.state = nested_irq_pkg::SEQ_SAVE_PSW;
				end else if (instr_done && take_mask) begin
					d.saved_psw = psw_image;
					d.ie = 1'b0;
					d.isp = (pick_code == 2'h0) ? `ISP_LEVEL_0_OR_1
						: pick_code - 2'h1;
					d.in_break = 1'b0;
					d.vector = IRQ_VECTOR_BASE
						+ 20'(pick_index) * `IRQ_VECTOR_STEP;
					d.is_break = 1'b0;
					d.source = 6'(pick_index);
					d.age = 4'h0;
					d.state = nested_irq_pkg::SEQ_SAVE_PSW;
				end else if (instr_done) begin
					unique case (instr_class)
						nested_irq_pkg::CLASS_ENABLE: d.ie = 1'b1;
						nested_irq_pkg::CLASS_DISABLE: d.ie = 1'b0;
						nested_irq_pkg::CLASS_PSW_WRITE: begin
							d.ie = psw_write_data[`PSW_IE_BIT];
							d.isp = {psw_write_data[`PSW_IN_SERVICE_LEVEL_BIT1_BIT],
								psw_write_data[`PSW_IN_SERVICE_LEVEL_BIT0_BIT]};
						end
						nested_irq_pkg::CLASS_RET_BREAK,
						nested_irq_pkg::CLASS_RET_IRQ: begin
							// status word is the second pop, after the pc
							d.ie = stack_psw_data[`PSW_IE_BIT];
							d.isp = {stack_psw_data[`PSW_IN_SERVICE_LEVEL_BIT1_BIT],
								stack_psw_data[`PSW_IN_SERVICE_LEVEL_BIT0_BIT]};
							// break state ends on its own return, or earlier on any maskable acknowledge
							if (instr_class == nested_irq_pkg::CLASS_RET_BREAK) begin
								d.in_break = 1'b0;
							end
						end
						default: d.ie = q.ie;
					endcase
				end
			end
			nested_irq_pkg::SEQ_SAVE_PSW: d.state = nested_irq_pkg::SEQ_SAVE_PC;
			nested_irq_pkg::SEQ_SAVE_PC: d.state = nested_irq_pkg::SEQ_BRANCH;
			nested_irq_pkg::SEQ_BRANCH: d.state = nested_irq_pkg::SEQ_IDLE;
			default: d.state = nested_irq_pkg::SEQ_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			q.state <= nested_irq_pkg::SEQ_IDLE;
			q.ie <= 1'b0;
			q.isp <= `ISP_NONE_IN_SERVICE;
			q.in_break <= 1'b0;
			q.age <= 4'h0;
			q.saved_psw <= `PSW_RESET_VALUE;
			q.vector <= 20'h00000;
			q.is_break <= 1'b0;
			q.source <= 6'h00;
		end else if (clk_en) begin
			q <= d;
		end
	end

	assign global_irq_enable = q.ie;
	assign in_service_level_bit1 = q.isp[1];
	assign in_service_level_bit0 = q.isp[0];
	assign program_status_word = psw_image;
	// the core must not start an instruction while the pushes run
	assign service_busy = q.state != nested_irq_pkg::SEQ_IDLE;
	assign ack_pulse = q.state == nested_irq_pkg::SEQ_SAVE_PSW;
	assign ack_is_break = q.is_break;
	assign ack_source = q.source;
	assign push_psw_valid = q.state == nested_irq_pkg::SEQ_SAVE_PSW;
	assign push_psw_data = q.saved_psw;
	assign push_pc_valid = q.state == nested_irq_pkg::SEQ_SAVE_PC;
	assign pc_load_valid = q.state == nested_irq_pkg::SEQ_BRANCH;
	assign pc_load_addr = q.vector;

endmodule

//--- tb/stack_model.sv
// cpu stack stand-in: keeps pushed status words for the returns
// assumes pop is raised with the return's instr_done pulse
`timescale 1ns/100ps
module stack_model (
	input wire logic clk_sys,
	input wire logic push_psw_valid,
	input wire logic [7:0] push_psw_data,
	input wire logic pop,
	output logic [7:0] stack_psw_data
);
	logic [7:0] mem [8];
	int sp = 0;
	// empty stack shows a pattern, never a stale word
	assign stack_psw_data = sp > 0 ? mem[sp-1] : 8'h5a;
	always @(posedge clk_sys) begin
		if (push_psw_valid) begin
			mem[sp] <= push_psw_data;
			sp <= sp + 1;
		end else if (pop && sp > 0) begin
			sp <= sp - 1;
		end
	end
endmodule

//--- tb/nested_irq_ack_assertions.sv
// timing checks on the acknowledge controller ports
// assumes the single clk_sys domain and rst
`timescale 1ns/100ps
module irq_ack_checker (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic instr_done,
	input wire nested_irq_pkg::instr_class_type instr_class,
	input wire logic [7:0] stack_psw_data,
	input wire logic global_irq_enable,
	input wire logic [7:0] program_status_word,
	input wire logic service_busy,
	input wire logic ack_is_break,
	input wire logic push_psw_valid,
	input wire logic push_pc_valid,
	input wire logic pc_load_valid,
	input wire logic [19:0] pc_load_addr
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic bnd;
	assign bnd = instr_done && clk_en && !service_busy;
	property p_brk;
		bnd && instr_class == 4'h1 |=> push_psw_valid && !global_irq_enable;
	endproperty
	a_brk: assert property (p_brk) else $error("break not taken");
	property p_seq;
		push_psw_valid |=> push_pc_valid ##1 pc_load_valid ##1 !service_busy;
	endproperty
	a_seq: assert property (p_seq) else $error("push order");
	property p_vec;
		pc_load_valid && ack_is_break |-> pc_load_addr == 20'h0007e;
	endproperty
	a_vec: assert property (p_vec) else $error("break vector");
	property p_ackie;
		$rose(push_psw_valid) |-> !global_irq_enable;
	endproperty
	a_ackie: assert property (p_ackie) else $error("enable kept");
	property p_ei;
		bnd && instr_class == 4'h4 |=> global_irq_enable;
	endproperty
	a_ei: assert property (p_ei) else $error("enable not set");
	property p_hold;
		bnd && instr_class > 4'h1 |=> !push_psw_valid;
	endproperty
	a_hold: assert property (p_hold) else $error("hold ignored");
	property p_off;
		bnd && instr_class == 4'h0 && !global_irq_enable |=> !push_psw_valid;
	endproperty
	a_off: assert property (p_off) else $error("taken while off");
	property p_ret;
		bnd && instr_class == 4'h3 |=>
			program_status_word == ($past(stack_psw_data) & 8'h86);
	endproperty
	a_ret: assert property (p_ret) else $error("return restore");
	c_brk: cover property (pc_load_valid && ack_is_break);
	c_irq: cover property (pc_load_valid && !ack_is_break);
	c_ret: cover property (bnd && instr_class == 4'h2);
endmodule
bind nested_irq_ack irq_ack_checker chk_u (.clk_sys, .rst, .clk_en,
	.instr_done, .instr_class, .stack_psw_data, .global_irq_enable,
	.program_status_word, .service_busy, .ack_is_break, .push_psw_valid,
	.push_pc_valid, .pc_load_valid, .pc_load_addr);

//--- tb/tb.sv
// self-checking bench for the acknowledge controller
// assumes stack_model stands in for the cpu stack
`timescale 1ns/100ps
module tb;
	logic clk_sys = 0, rst = 1, instr_done = 0;
	logic [3:0] rq = 0, mk = 0, ph = 0, pl = 0, c = 0;
	logic [3:0] hl [7] = '{4'h4, 4'h6, 4'h7, 4'h8, 4'h3, 4'h2, 4'h5};
	logic [7:0] spd, pswv, ppd;
	logic ie, i1, i0, busy, ack, psv;
	logic [5:0] src;
	logic [19:0] pca;
	nested_irq_pkg::instr_class_type cls;
	int miscompares = 0, num_checks = 0;
	wire logic pop = instr_done && (c == 4'h2 || c == 4'h3);
	assign cls = nested_irq_pkg::instr_class_type'(c);
	nested_irq_ack #(.SOURCES(4)) dut_u (.clk_sys, .rst, .clk_en(1'b1),
		.request_flag(rq), .request_mask_flag(mk), .priority_high_bit(ph),
		.priority_low_bit(pl), .instr_done, .instr_class(cls),
		.psw_write_data(8'h86), .stack_psw_data(spd),
		.global_irq_enable(ie), .in_service_level_bit1(i1),
		.in_service_level_bit0(i0), .program_status_word(pswv),
		.service_busy(busy), .ack_pulse(ack), .ack_is_break(),
		.ack_source(src), .push_psw_valid(psv), .push_psw_data(ppd),
		.push_pc_valid(), .pc_load_valid(), .pc_load_addr(pca));
	stack_model stk_u (.clk_sys, .push_psw_valid(psv),
		.push_psw_data(ppd), .pop, .stack_psw_data(spd));
	initial forever #10 clk_sys = ~clk_sys;
	task chk(input logic [19:0] s, input logic [19:0] e);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %0t got %h want %h", $time, s, e);
		end
	endtask
	// seven idle clocks first so any request has aged past the minimum
	task step(input logic [3:0] k, input logic e);
		repeat (7) @(posedge clk_sys);
		#1 c = k;
		instr_done = 1;
		@(posedge clk_sys);
		#1 instr_done = 0;
		chk(ack, e);
		repeat (4) @(posedge clk_sys);
		#1;
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#100000;
		miscompares++;
		end_sim;
	end
	// source setup below is {request, mask, prio high, prio low}
	initial begin
		repeat (10) @(posedge clk_sys);
		#1 rst = 0;
		chk(pswv, 8'h06);
		step(4'h1, 1);
		chk(pca, 20'h0007e);
		chk(ppd, 8'h06);
		step(4'h4, 0);
		{rq, mk, ph, pl} = 16'h4044;
		step(4'h0, 1);
		chk(src, 20'h2);
		chk({i1, i0}, 2'h2);
		chk(pca, 20'h8);
		chk(ie, 0);
		rq = 0;
		step(4'h3, 0);
		chk(pswv, 8'h86);
		step(4'h2, 0);
		chk(pswv, 8'h06);
		step(4'h4, 0);
		step(4'h1, 1);
		step(4'h4, 0);
		step(4'h1, 1);
		{rq, mk, ph, pl} = 16'h2000;
		foreach (hl[i]) step(hl[i], 1'b0);
		step(4'h0, 0);
		step(4'h4, 0);
		step(4'h0, 1);
		chk({i1, i0}, 2'h0);
		{rq, mk, ph, pl} = 16'h8008;
		step(4'h4, 0);
		step(4'h0, 0);
		rq = 4'h9;
		step(4'h0, 1);
		chk(src, 20'h0);
		rst = 1;
		@(posedge clk_sys);
		#1 rst = 0;
		chk({ie, i1, i0}, 3'h3);
		{rq, mk, ph, pl} = 16'hd1c0;
		step(4'h4, 0);
		step(4'h0, 1);
		chk(src, 20'h2);
		chk({i1, i0}, 2'h1);
		rq = 4'h8;
		step(4'h4, 0);
		step(4'h0, 0);
		{rq, mk, ph, pl} = 16'ha182;
		step(4'h0, 1);
		chk(src, 20'h1);
		chk({i1, i0}, 2'h0);
		rq = 0;
		step(4'h4, 0);
		{rq, mk, ph, pl} = 16'h1000;
		@(posedge clk_sys);
		#1 c = 4'h0;
		instr_done = 1;
		@(posedge clk_sys);
		#1 instr_done = 0;
		chk(ack, 0);
		step(4'h0, 1);
		chk(src, 20'h0);
		end_sim;
	end
endmodule
